// file: design/acmd_decode.sv
// command code decoder: class, action and parameter use
`timescale 1ns/1ns
module acmd_decode
	import acmd_pkg::*;
(
	input  wire logic [7:0]  cmd_code,
	output acmd_class_t      cmd_class,
	output acmd_kind_t       cmd_kind,
	output logic             cmd_use_head
);

	// ======================================================================
	// decode table
	typedef struct packed {
		acmd_class_t cls;
		acmd_kind_t  kind;
		logic        head;
	} acmd_dec_t;

	function automatic acmd_dec_t decode(input logic [7:0] code);
		acmd_dec_t d;
		d = '{ACMD_CLS_1, ACMD_KIND_MEDIA, 1'b0};
		// nibble families first, low nibble is don't-care
		case (code[7:4])
			4'h1:    return '{ACMD_CLS_1, ACMD_KIND_NOP, 1'b0};
			4'h7:    return '{ACMD_CLS_1, ACMD_KIND_NOP, 1'b1};
			default: d = d;
		endcase
		case (code)
			8'h00:               d = '{ACMD_CLS_1, ACMD_KIND_NOP, 1'b0};
			8'h98, 8'he5:        d = '{ACMD_CLS_1, ACMD_KIND_POWER, 1'b0};
			8'hc0:               d = '{ACMD_CLS_1, ACMD_KIND_ERASE, 1'b1};
			8'h30, 8'h31, 8'h38,
			8'hca, 8'h50:        d = '{ACMD_CLS_2, ACMD_KIND_MEDIA, 1'b1};
			8'he8:               d = '{ACMD_CLS_2, ACMD_KIND_MEDIA, 1'b0};
			8'hc5, 8'hcd, 8'h3c: d = '{ACMD_CLS_3, ACMD_KIND_MEDIA, 1'b1};
			8'hf8:               d = '{ACMD_CLS_1, ACMD_KIND_MEDIA, 1'b0};
			8'hf9, 8'h91, 8'hc8, 8'hc4, 8'h20, 8'h21,
			8'h40, 8'h41, 8'h87, 8'hf5:
			                     d = '{ACMD_CLS_1, ACMD_KIND_MEDIA, 1'b1};
			8'h90, 8'he7, 8'hec, 8'he3, 8'h97, 8'he1, 8'h95, 8'he4,
			8'h03, 8'hef, 8'hc6, 8'he6, 8'h99, 8'hb0, 8'he2, 8'h96,
			8'he0, 8'h94:        d = '{ACMD_CLS_1, ACMD_KIND_MEDIA, 1'b0};
			default:             d = '{ACMD_CLS_NONE, ACMD_KIND_ABORT, 1'b0};
		endcase
		return d;
	endfunction : decode

	// ======================================================================
	// outputs
	acmd_dec_t dec;
	assign dec          = decode(cmd_code);
	assign cmd_class    = dec.cls;
	assign cmd_kind     = dec.kind;
	assign cmd_use_head = dec.head;

endmodule : acmd_decode

// file: design/acmd_map.svh
// register offsets, field positions, reset values and timing figures of the command acceptor
`ifndef ACMD_MAP_SVH
`define ACMD_MAP_SVH

// ==========================================================================
// task file offsets
`define ACMD_OFS_FEATURE   4'h1
`define ACMD_OFS_SCOUNT    4'h2
`define ACMD_OFS_SNUM      4'h3
`define ACMD_OFS_CYLLO     4'h4
`define ACMD_OFS_CYLHI     4'h5
`define ACMD_OFS_DRVHD     4'h6
`define ACMD_OFS_CMD       4'h7
`define ACMD_OFS_CTRL      4'he

// ==========================================================================
// reset values
`define ACMD_RST_SCOUNT    8'h01
`define ACMD_RST_SNUM      8'h01
`define ACMD_RST_DRVHD     8'ha0

// ==========================================================================
// field positions
`define ACMD_DH_LBA        6
`define ACMD_DH_DRV        4
`define ACMD_ST_BUSY       7
`define ACMD_ST_RDY        6
`define ACMD_ST_DWF        5
`define ACMD_ST_DSC        4
`define ACMD_ST_DRQ        3
`define ACMD_ST_ERR        0
`define ACMD_ER_ABRT       2
`define ACMD_DC_SRST       2
`define ACMD_DC_NIEN       1

// ==========================================================================
// power mode replies loaded into the sector count
`define ACMD_PWR_STANDBY   8'h00
`define ACMD_PWR_IDLE      8'hff

// ==========================================================================
// timing
`define ACMD_CLK_MHZ       100
`define ACMD_DRQ2_US       700
`define ACMD_DRQ3_MS       20

`endif

// file: design/acmd_pkg.sv
// types shared by the command acceptor modules
package acmd_pkg;

	// ======================================================================
	// acceptance class of a command code
	typedef enum logic [1:0] {
		ACMD_CLS_NONE = 2'h0,
		ACMD_CLS_1    = 2'h1,
		ACMD_CLS_2    = 2'h2,
		ACMD_CLS_3    = 2'h3
	} acmd_class_t;

	// ======================================================================
	// what the acceptor does with a command
	typedef enum logic [2:0] {
		ACMD_KIND_NOP   = 3'h0,
		ACMD_KIND_POWER = 3'h1,
		ACMD_KIND_MEDIA = 3'h2,
		ACMD_KIND_ERASE = 3'h3,
		ACMD_KIND_ABORT = 3'h4
	} acmd_kind_t;

	// ======================================================================
	// sequencer states, gray from idle through accept and prep to data
	typedef enum logic [2:0] {
		ACMD_ST_IDLE   = 3'b000,
		ACMD_ST_ACCEPT = 3'b001,
		ACMD_ST_PREP   = 3'b011,
		ACMD_ST_DATA   = 3'b010,
		ACMD_ST_EXEC   = 3'b110,
		ACMD_ST_FINISH = 3'b100
	} acmd_state_t;

endpackage : acmd_pkg

// file: design/acmd_top.sv
// task file command acceptance and dispatch sequencer
// Notes on behaviour
// - class 1 command raises busy quickly
// - class 2: busy, buffer, request, release
// - class 3: same with longer request deadline
// - legacy codes complete as no operation
// - sector writes, buffer write, format: class 2
// - multiple writes and write verify: class 3
// - native max and set max decoded
// - marked parameters are taken as valid
// - drive-only commands ignore head field
// - two power check codes, drive bit only
// - standby power check loads zero count
// - idle power check loads all ones
// - erase conditions sectors for later writes
// - erase never requests data, may fault
// - erase address from chs or lba fields
// - zero sector count means 256
// - data request set on need, next command clears
// - status read clears interrupt, alternate does not
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ns
`include "acmd_map.svh"
module acmd_top
	import acmd_pkg::*;
#(
	parameter int unsigned DRQ2_CYCLES = `ACMD_DRQ2_US * `ACMD_CLK_MHZ,
	parameter int unsigned DRQ3_CYCLES = `ACMD_DRQ3_MS * 1000 * `ACMD_CLK_MHZ,
	parameter int unsigned CNT_W       = 22
)(
	input  wire logic        mclk,
	input  wire logic        reset,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	output logic             busy_flag,
	output logic             data_request_flag,
	output logic             intrq,
	input  wire logic        card_ready,
	input  wire logic        card_drive,
	input  wire logic        card_standby,
	output logic             media_start,
	output logic      [7:0]  media_cmd,
	output logic      [7:0]  media_feature,
	output logic      [8:0]  media_count,
	output logic      [27:0] media_addr,
	output logic             media_lba,
	output logic             media_erase,
	output logic             media_buf_prep,
	input  wire logic        media_buf_ready,
	input  wire logic        media_data_req,
	input  wire logic        media_xfer_done,
	input  wire logic        media_done,
	input  wire logic        media_fault
);

	// ======================================================================
	// functions
	// a zero count asks for a full 256 sectors
	function automatic logic [8:0] sectors(input logic [7:0] sc);
		return (sc == 8'h00) ? 9'h100 : {1'b0, sc};
	endfunction : sectors

	// ======================================================================
	// storage
	logic [7:0]  feature_param_reg;
	logic [7:0]  sector_count_reg;
	logic [7:0]  sector_number_reg;
	logic [15:0] cylinder_regs;
	logic [7:0]  drive_head_reg;
	logic [7:0]  cmd_reg;
	logic        write_fault_flag;
	logic        err_flag;
	logic        abort_flag;
	logic        int_pend;
	logic        int_off;
	logic        soft_rst;
	acmd_state_t state;
	acmd_class_t cls_q;
	logic [CNT_W-1:0] wait_cnt;

	// ======================================================================
	// register port decode
	wire sel_feat  = (reg_addr == `ACMD_OFS_FEATURE);
	wire sel_sc    = (reg_addr == `ACMD_OFS_SCOUNT);
	wire sel_sn    = (reg_addr == `ACMD_OFS_SNUM);
	wire sel_cl    = (reg_addr == `ACMD_OFS_CYLLO);
	wire sel_ch    = (reg_addr == `ACMD_OFS_CYLHI);
	wire sel_dh    = (reg_addr == `ACMD_OFS_DRVHD);
	wire sel_cmd   = (reg_addr == `ACMD_OFS_CMD);
	wire sel_ctrl  = (reg_addr == `ACMD_OFS_CTRL);
	// task file is locked to the host while busy
	wire tf_wr     = reg_wr && !busy_flag && !soft_rst;
	wire mine      = (drive_head_reg[`ACMD_DH_DRV] == card_drive);
	wire cmd_wr    = tf_wr && sel_cmd && mine;
	wire stat_rd   = reg_rd && sel_cmd;
	wire ctrl_wr   = reg_wr && sel_ctrl;

	// ======================================================================
	// decoder
	acmd_class_t dec_class;
	acmd_kind_t  dec_kind;
	logic        dec_head;

	acmd_decode u_decode (
		.cmd_code     (cmd_reg),
		.cmd_class    (dec_class),
		.cmd_kind     (dec_kind),
		.cmd_use_head (dec_head)
	);

	// ======================================================================
	// status byte and read mux
	wire [7:0] status_byte = {busy_flag, card_ready, write_fault_flag, card_ready,
	                          data_request_flag, 1'b0, 1'b0, err_flag};
	wire [7:0] error_byte  = {5'h00, abort_flag, 2'h0};
	wire [7:0] rd_mux =
		sel_feat ? error_byte :
		sel_sc   ? sector_count_reg :
		sel_sn   ? sector_number_reg :
		sel_cl   ? cylinder_regs[7:0] :
		sel_ch   ? cylinder_regs[15:8] :
		sel_dh   ? drive_head_reg :
		(sel_cmd || sel_ctrl) ? status_byte : 8'h00;

	// ======================================================================
	// sequencer conditions
	wire [CNT_W-1:0] drq_limit = (cls_q == ACMD_CLS_3) ? DRQ3_CYCLES[CNT_W-1:0]
	                                                   : DRQ2_CYCLES[CNT_W-1:0];
	wire prep_late  = (wait_cnt >= drq_limit - 1'b1);
	wire go_prep    = (state == ACMD_ST_ACCEPT) && (dec_class == ACMD_CLS_2 ||
	                  dec_class == ACMD_CLS_3);
	wire go_exec    = (state == ACMD_ST_ACCEPT) && (dec_kind == ACMD_KIND_MEDIA ||
	                  dec_kind == ACMD_KIND_ERASE) && !go_prep;
	wire buf_ok     = (state == ACMD_ST_PREP) && media_buf_ready;
	wire finish     = (state == ACMD_ST_FINISH);
	wire pwr_reply  = (state == ACMD_ST_ACCEPT) && (dec_kind == ACMD_KIND_POWER);
	wire do_abort   = ((state == ACMD_ST_ACCEPT) && (dec_kind == ACMD_KIND_ABORT)) ||
	                  ((state == ACMD_ST_PREP) && !media_buf_ready && prep_late);
	wire back_done  = (state == ACMD_ST_EXEC || state == ACMD_ST_DATA) && media_done;

	acmd_state_t next_state;
	always_comb begin
		next_state = state;
		case (state)
			ACMD_ST_IDLE:   if (cmd_wr) next_state = ACMD_ST_ACCEPT;
			ACMD_ST_ACCEPT: begin
				if (go_prep)
					next_state = ACMD_ST_PREP;
				else if (go_exec)
					next_state = ACMD_ST_EXEC;
				else
					next_state = ACMD_ST_FINISH;
			end
			ACMD_ST_PREP: begin
				if (buf_ok)
					next_state = ACMD_ST_DATA;
				else if (prep_late)
					next_state = ACMD_ST_FINISH;
			end
			ACMD_ST_DATA:   if (media_done) next_state = ACMD_ST_FINISH;
			ACMD_ST_EXEC:   if (media_done) next_state = ACMD_ST_FINISH;
			ACMD_ST_FINISH: next_state = ACMD_ST_IDLE;
			default:        next_state = ACMD_ST_IDLE;
		endcase
	end

	// ======================================================================
	// sequencer state, soft reset holds it idle
	always_ff @(posedge mclk or posedge reset) begin
		if (reset)
			state <= ACMD_ST_IDLE;
		else if (soft_rst)
			state <= ACMD_ST_IDLE;
		else
			state <= next_state;
	end

	// deadline counter for the class 2 and 3 buffer set-up
	always_ff @(posedge mclk or posedge reset) begin
		if (reset)
			wait_cnt <= '0;
		else if (state == ACMD_ST_PREP)
			wait_cnt <= wait_cnt + 1'b1;
		else
			wait_cnt <= '0;
	end

	// ======================================================================
	// device control: soft reset and interrupt disable, writable while busy
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			soft_rst <= 1'b0;
			int_off  <= 1'b0;
		end else if (ctrl_wr) begin
			soft_rst <= reg_wdata[`ACMD_DC_SRST];
			int_off  <= reg_wdata[`ACMD_DC_NIEN];
		end
	end

	// ======================================================================
	// parameter registers, sector count also takes the power reply
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			feature_param_reg <= 8'h00;
			sector_number_reg <= `ACMD_RST_SNUM;
			cylinder_regs     <= 16'h0000;
			drive_head_reg    <= `ACMD_RST_DRVHD;
			cmd_reg           <= 8'h00;
		end else begin
			if (tf_wr && sel_feat) feature_param_reg   <= reg_wdata;
			if (tf_wr && sel_sn)   sector_number_reg   <= reg_wdata;
			if (tf_wr && sel_cl)   cylinder_regs[7:0]  <= reg_wdata;
			if (tf_wr && sel_ch)   cylinder_regs[15:8] <= reg_wdata;
			if (tf_wr && sel_dh)   drive_head_reg      <= reg_wdata;
			if (cmd_wr)            cmd_reg             <= reg_wdata;
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset)
			sector_count_reg <= `ACMD_RST_SCOUNT;
		else if (pwr_reply)
			sector_count_reg <= card_standby ? `ACMD_PWR_STANDBY
			                                 : `ACMD_PWR_IDLE;
		else if (tf_wr && sel_sc)
			sector_count_reg <= reg_wdata;
	end

	// ======================================================================
	// busy: set on the edge after the command write, well inside 400 ns
	always_ff @(posedge mclk or posedge reset) begin
		if (reset)
			busy_flag <= 1'b0;
		else if (soft_rst)
			busy_flag <= 1'b0;
		else if (cmd_wr)
			busy_flag <= 1'b1;
		else if (buf_ok || finish)
			busy_flag <= 1'b0;
	end

	// data request: buffer ready or back end need; erase never gets here
	always_ff @(posedge mclk or posedge reset) begin
		if (reset)
			data_request_flag <= 1'b0;
		else if (soft_rst || cmd_wr)
			data_request_flag <= 1'b0;
		else if (buf_ok || (media_data_req && state == ACMD_ST_EXEC &&
		         cls_q == ACMD_CLS_1 && !media_erase))
			data_request_flag <= 1'b1;
		else if (media_xfer_done)
			data_request_flag <= 1'b0;
	end

	// ======================================================================
	// completion status, cleared by the next command
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			err_flag         <= 1'b0;
			abort_flag       <= 1'b0;
			write_fault_flag <= 1'b0;
		end else if (soft_rst || cmd_wr) begin
			err_flag         <= 1'b0;
			abort_flag       <= 1'b0;
			write_fault_flag <= 1'b0;
		end else if (do_abort) begin
			err_flag         <= 1'b1;
			abort_flag       <= 1'b1;
		end else if (back_done && media_fault) begin
			err_flag         <= 1'b1;
			write_fault_flag <= 1'b1;
		end
	end

	// interrupt pending: completion set wins over a status read clear
	always_ff @(posedge mclk or posedge reset) begin
		if (reset)
			int_pend <= 1'b0;
		else if (soft_rst)
			int_pend <= 1'b0;
		else if (finish)
			int_pend <= 1'b1;
		else if (stat_rd)
			int_pend <= 1'b0;
	end

	assign intrq = int_pend && !int_off;

	// ======================================================================
	// back end dispatch, latched so outputs other than the one-cycle start pulse stand for the whole command
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			media_start    <= 1'b0;
			media_cmd      <= 8'h00;
			media_feature  <= 8'h00;
			media_count    <= 9'h000;
			media_addr     <= 28'h0000000;
			media_lba      <= 1'b0;
			media_erase    <= 1'b0;
			media_buf_prep <= 1'b0;
			cls_q          <= ACMD_CLS_NONE;
		end else begin
			media_start <= go_prep || go_exec;
			if (state == ACMD_ST_ACCEPT) begin
				cls_q          <= dec_class;
				media_cmd      <= cmd_reg;
				media_feature  <= feature_param_reg;
				media_count    <= sectors(sector_count_reg);
				media_lba      <= drive_head_reg[`ACMD_DH_LBA];
				// head nibble only passes for commands that use it
				media_addr     <= {dec_head ? drive_head_reg[3:0] : 4'h0,
				                   cylinder_regs, sector_number_reg};
				media_erase    <= (dec_kind == ACMD_KIND_ERASE);
				media_buf_prep <= go_prep;
			end else if (state == ACMD_ST_IDLE) begin
				media_buf_prep <= 1'b0;
			end
		end
	end

	// ======================================================================
	// read data stands in the cycle after the strobe only
	always_ff @(posedge mclk or posedge reset) begin
		if (reset)
			reg_rdata <= 8'h00;
		else if (reg_rd)
			reg_rdata <= rd_mux;
		else
			reg_rdata <= 8'h00;
	end

endmodule : acmd_top

// file: tb/acmd_media_model.sv
// behavioural back end answering dispatched commands
`timescale 1ns/1ns
module acmd_media_model (
	input wire logic mclk,
	input wire logic reset,
	input wire logic media_start,
	input wire logic media_buf_prep,
	input wire logic media_erase,
	input wire logic [31:0] dly,
	input wire logic hang,
	input wire logic fault,
	output logic     media_buf_ready,
	output logic     media_data_req,
	output logic     media_xfer_done,
	output logic     media_done,
	output logic     media_fault
);
	initial {media_buf_ready, media_data_req, media_xfer_done, media_done, media_fault} = '0;

	// ======================================================================
	// one job at a time; hang leaves the buffer unready to force a timeout
	always @(posedge mclk) begin
		if (media_start && !reset) begin
			repeat (dly) @(posedge mclk);
			if (!hang) begin
				media_buf_ready <= media_buf_prep;
				media_data_req  <= !media_buf_prep && !media_erase;
				@(posedge mclk);
				media_buf_ready <= 1'b0;
				media_data_req  <= 1'b0;
				media_xfer_done <= !media_erase;
				@(posedge mclk);
				media_xfer_done <= 1'b0;
				media_fault     <= fault;
				media_done      <= 1'b1;
				@(posedge mclk);
				media_done      <= 1'b0;
				media_fault     <= 1'b0;
			end
		end
	end
endmodule : acmd_media_model

// file: tb/acmd_monitor.sv
// port-level assertions for the command acceptor
`timescale 1ns/1ns
module acmd_monitor (
	input wire logic       mclk,
	input wire logic       reset,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic       busy_flag,
	input wire logic       data_request_flag,
	input wire logic       intrq,
	input wire logic       card_drive,
	input wire logic       media_start,
	input wire logic       media_buf_prep,
	input wire logic       media_erase,
	input wire logic [8:0] media_count,
	input wire logic       media_buf_ready,
	input wire logic       media_data_req
);
	// ======================================================================
	// shadow of drive select and soft reset, so a taken command is known
	logic drv;
	logic srst;
	wire  take = reg_wr && reg_addr == 4'h7 && !busy_flag && !srst && drv == card_drive;

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			drv  <= 1'b0;
			srst <= 1'b0;
		end else begin
			if (reg_wr && reg_addr == 4'he)
				srst <= reg_wdata[2];
			if (reg_wr && reg_addr == 4'h6 && !busy_flag && !srst)
				drv <= reg_wdata[4];
		end
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (reset);

	// ======================================================================
	// acceptance and class timing
	busy_take_a: assert property (take |=> busy_flag)
		else $error("busy not raised after command");
	nop_done_a: assert property (take && (reg_wdata == 8'h00 || reg_wdata[7:4] == 4'h1
		|| reg_wdata[7:4] == 4'h7) |=> busy_flag && !media_start ##1 !media_start ##1 !busy_flag)
		else $error("no-op did not complete quietly");
	pwr_done_a: assert property (take && reg_wdata inside {8'h98, 8'he5} |-> ##3 !busy_flag)
		else $error("power check not finished");
	wr2_start_a: assert property (take && reg_wdata inside {8'h30, 8'h31, 8'h38, 8'hca,
		8'he8, 8'h50} |-> ##2 media_start && media_buf_prep)
		else $error("class 2 buffer not prepared");
	wr3_start_a: assert property (take && reg_wdata inside {8'hc5, 8'hcd, 8'h3c}
		|-> ##2 media_start && media_buf_prep)
		else $error("class 3 buffer not prepared");
	drq_frees_a: assert property ($rose(data_request_flag) && media_buf_prep |-> !busy_flag)
		else $error("busy held with data request");
	drq_cause_a: assert property ($rose(data_request_flag)
		|-> $past(media_buf_ready) || $past(media_data_req))
		else $error("data request without cause");
	erase_nodrq_a: assert property (media_start && media_erase
		|-> !data_request_flag throughout ##[1:1000] !busy_flag)
		else $error("erase raised data request");
	count_range_a: assert property (media_start |-> media_count inside {[9'h001:9'h100]})
		else $error("sector count out of range");
	stat_clear_a: assert property (reg_rd && reg_addr == 4'h7 |=> !intrq)
		else $error("status read kept interrupt");
	alt_keep_a: assert property (reg_rd && reg_addr == 4'he && intrq |=> intrq)
		else $error("alternate read cleared interrupt");
endmodule : acmd_monitor

// file: tb/acmd_tb_top.sv
// self-checking bench for the command acceptor
`timescale 1ns/1ns
module acmd_tb_top;
	logic        mclk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [3:0]  reg_addr = 4'h0;
	logic [7:0]  reg_wdata = 8'h00, reg_rdata, media_cmd, media_feature;
	logic        busy_flag, data_request_flag, intrq, media_start, media_lba, media_erase;
	logic        card_ready = 1'b1, card_drive = 1'b0, card_standby = 1'b0, media_buf_prep;
	logic [8:0]  media_count;
	logic [27:0] media_addr;
	logic        media_buf_ready, media_data_req, media_xfer_done, media_done, media_fault;
	logic        hang = 1'b0, fault = 1'b0, rd_d = 1'b0;
	int          dly = 2, n_fail = 0, total_checks = 0, cyc = 0;
	logic [31:0] rs = 32'd31279;
	logic [15:0] q[$];
	logic [15:0] qe;

	acmd_top #(.DRQ2_CYCLES(20), .DRQ3_CYCLES(40)) DUT (.*);
	acmd_media_model BE (.*);

	always #5 mclk = ~mclk;

	function automatic logic [7:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs[7:0];
	endfunction : rnd

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : tally_and_finish

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		@(posedge mclk);
	endtask : wr

	// read data is checked later by the watcher, with a mask for loose bits
	task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
		q.push_back({m, e});
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(posedge mclk);
	endtask : rd

	// 0 start pulse, 1 data request, 2 interrupt; bounded wait
	task automatic till(input int w);
		int n;
		for (n = 0; n < 3000; n++) begin
			#1;
			if ((w == 0 && media_start === 1'b1) || (w == 1 && data_request_flag === 1'b1)
				|| (w == 2 && intrq === 1'b1))
				break;
			@(posedge mclk);
		end
		chk(n < 3000, 1'b1);
		// realign to the edge so the next request starts right after it
		@(posedge mclk);
	endtask : till

	// ======================================================================
	// watcher: read data stands the cycle after the strobe
	always @(posedge mclk) begin
		if (rd_d) begin
			qe = q.pop_front();
			chk(reg_rdata & qe[15:8], qe[7:0] & qe[15:8]);
		end
		rd_d <= reg_rd;
	end

	// hang guard
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			tally_and_finish();
		end
	end

	// ======================================================================
	// main sequence: every code class at least once, then a buffer timeout and a foreign drive
	initial begin
		logic [7:0] cd [19] = '{8'h00, 8'h1a, 8'h7f, 8'h98, 8'he5, 8'h20, 8'hf8, 8'hf9, 8'hc0,
			8'h30, 8'h31, 8'h38, 8'hca, 8'he8, 8'h50, 8'hc5, 8'hcd, 8'h3c, 8'h02};
		int         kd [19] = '{0, 0, 0, 1, 1, 2, 2, 2, 5, 3, 3, 3, 3, 3, 3, 4, 4, 4, 6};
		logic [7:0] sc, sn, cl, ch, hd, st;
		logic [3:0] eh;
		int         t;
		repeat (4) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		rd(4'h2, 8'h01, 8'hff);
		rd(4'h3, 8'h01, 8'hff);
		rd(4'h6, 8'ha0, 8'hff);
		rd(4'h7, 8'h50, 8'hff);
		rd(4'h9, 8'h00, 8'hff);
		for (int i = 0; i < 19; i++) begin
			sc = (i == 9) ? 8'h00 : rnd();
			sn = rnd();
			cl = rnd();
			ch = rnd();
			hd = rnd();
			card_standby <= i[0];
			fault <= (kd[i] == 5);
			dly = (kd[i] == 4) ? 30 : (kd[i] == 3) ? 12 : 1 + (rnd() % 4);
			wr(4'h2, sc);
			wr(4'h3, sn);
			wr(4'h4, cl);
			wr(4'h5, ch);
			wr(4'h1, sn ^ 8'h5a);
			wr(4'h6, {1'b1, hd[6], 2'b10, hd[3:0]});
			// drive-only commands must not pass the head field on
			eh = (cd[i] == 8'hf8 || cd[i] == 8'he8) ? 4'h0 : hd[3:0];
			t = cyc;
			wr(4'h7, cd[i]);
			if (kd[i] >= 2 && kd[i] <= 5) begin
				till(0);
				chk(media_cmd, cd[i]);
				chk(media_count, (sc == 8'h00) ? 9'h100 : {1'b0, sc});
				chk(media_feature, sn ^ 8'h5a);
				chk(media_addr, {eh, ch, cl, sn});
				chk(media_lba, hd[6]);
				chk(media_erase, kd[i] == 5);
				chk(media_buf_prep, kd[i] == 3 || kd[i] == 4);
			end
			if (kd[i] == 3 || kd[i] == 4) begin
				till(1);
				chk(busy_flag, 1'b0);
				chk(cyc - t <= ((kd[i] == 3) ? 25 : 45), 1'b1);
			end
			till(2);
			chk(busy_flag, 1'b0);
			st = {2'b01, kd[i] == 5, 4'h8, kd[i] == 5 || kd[i] == 6};
			rd(4'he, st, 8'hff);
			chk(intrq, 1'b1);
			rd(4'h7, st, 8'hff);
			chk(intrq, 1'b0);
			if (kd[i] == 1)
				rd(4'h2, i[0] ? 8'h00 : 8'hff, 8'hff);
			if (kd[i] == 6)
				rd(4'h1, 8'h04, 8'hff);
		end
		// buffer never ready: class 2 must abort on its deadline
		hang <= 1'b1;
		wr(4'h7, 8'h30);
		till(2);
		rd(4'h7, 8'h51, 8'hff);
		rd(4'h1, 8'h04, 8'hff);
		// command for the other drive is dropped
		wr(4'h6, 8'hb0);
		wr(4'h7, 8'h00);
		chk(busy_flag, 1'b0);
		repeat (4) @(posedge mclk);
		chk(intrq, 1'b0);
		// interrupt disabled: a no-op still completes but stays silent
		wr(4'he, 8'h02);
		wr(4'h6, 8'ha0);
		wr(4'h7, 8'h00);
		repeat (4) @(posedge mclk);
		chk(busy_flag, 1'b0);
		chk(intrq, 1'b0);
		rd(4'h7, 8'h50, 8'hff);
		tally_and_finish();
	end
endmodule : acmd_tb_top

bind acmd_top acmd_monitor mon (.*);
